// File: hw/flash_master_access_protect.sv
// Flash master access protection register and request gate toward the flash array.
`timescale 1ns/1ps
`default_nettype none
module flash_master_access_protect (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_valid,
  input wire logic [7:0] reg_offset,
  input wire logic reg_write,
  input wire logic reg_priv,
  input wire logic reg_len32,
  input wire logic [31:0] reg_wdata,
  output logic reg_ack_q,
  output logic reg_err_q,
  output logic [31:0] reg_rdata_q,
  input wire logic acc_valid,
  input wire logic [1:0] acc_master,
  input wire logic acc_write,
  input wire logic acc_instr,
  input wire logic [31:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  input wire logic instruction_prefetch_enable,
  input wire logic data_prefetch_enable,
  output logic flash_req_q,
  output logic flash_write_q,
  output logic [31:0] flash_addr_q,
  output logic [31:0] flash_wdata_q,
  output logic flash_prefetch_q,
  output logic acc_error_q
);
  logic [31:0] prot_q;
  logic [31:0] prot_d;
  wire logic hit;
  wire logic wr_ok;
  wire logic reg_bad;
  wire logic allowed;
  wire logic prefetch_ok;
  wire logic [31:0] read_view;
  wire logic [1:0] req_field;
  wire logic req_pf_off;
  wire logic req_pf_en;

  assign hit = reg_offset == flash_protect_pkg::PROT_OFFSET;
  // Writes in user mode or narrower than a word are refused with an error.
  assign wr_ok = reg_valid && hit && reg_write && reg_priv && reg_len32;
  assign reg_bad = reg_valid && (!hit || (reg_write && !(reg_priv && reg_len32)));
  // Only the prefetch-off and grant bits take written data; reserved bits keep
  // their values even if software breaks the no-write convention.
  assign prot_d = wr_ok ? ((prot_q & ~flash_protect_pkg::PROT_WRITE_MASK)
                           | (reg_wdata & flash_protect_pkg::PROT_WRITE_MASK))
                        : prot_q;
  assign read_view = prot_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prot_q <= flash_protect_pkg::PROT_RESET;
    end else begin
      prot_q <= prot_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_ack_q <= 1'b0;
      reg_err_q <= 1'b0;
      reg_rdata_q <= flash_protect_pkg::ZERO_WORD;
    end else begin
      reg_ack_q <= reg_valid && !reg_bad;
      reg_err_q <= reg_bad;
      reg_rdata_q <= (reg_valid && hit && !reg_write) ? read_view : flash_protect_pkg::ZERO_WORD;
    end
  end

  master_access_check u_check (
    .prot(prot_q),
    .master(acc_master),
    .is_write(acc_write),
    .is_instr(acc_instr),
    .instruction_prefetch_enable(instruction_prefetch_enable),
    .data_prefetch_enable(data_prefetch_enable),
    .allowed(allowed),
    .prefetch_ok(prefetch_ok)
  );

  // A refused request never reaches the array, so a blocked master cannot
  // even leave a speculative fetch behind it.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flash_req_q <= 1'b0;
      flash_write_q <= 1'b0;
      flash_addr_q <= flash_protect_pkg::ZERO_WORD;
      flash_wdata_q <= flash_protect_pkg::ZERO_WORD;
      flash_prefetch_q <= 1'b0;
      acc_error_q <= 1'b0;
    end else begin
      flash_req_q <= acc_valid && allowed;
      flash_write_q <= acc_valid && allowed && acc_write;
      flash_addr_q <= acc_addr;
      flash_wdata_q <= acc_wdata;
      flash_prefetch_q <= acc_valid && allowed && prefetch_ok;
      acc_error_q <= acc_valid && !allowed;
    end
  end

  // The assertions decode the request on their own, so a slip in the check
  // module cannot hide behind a copy of its own expression.
  function automatic logic [1:0] field_of(input logic [31:0] r, input logic [1:0] m);
    field_of = r[flash_protect_pkg::GRANT_LO + flash_protect_pkg::GRANT_W * 32'(m)
                 +: flash_protect_pkg::GRANT_W];
  endfunction

  assign req_field = field_of(prot_q, acc_master);
  assign req_pf_off = prot_q[flash_protect_pkg::PF_OFF_LO + 32'(acc_master)];
  assign req_pf_en = acc_instr ? instruction_prefetch_enable : data_prefetch_enable;

  sequence priv_word_write;
    reg_valid && hit && reg_write && reg_priv && reg_len32;
  endsequence

  sequence refused_write;
    reg_valid && reg_write && !(reg_priv && reg_len32);
  endsequence

  sequence read_request;
    reg_valid && hit && !reg_write;
  endsequence

  sequence granted_read;
    acc_valid && !acc_write && req_field[flash_protect_pkg::GRANT_READ_BIT];
  endsequence

  chk_top_byte_zero: assert property (@(posedge clk) disable iff (!rstn)
    reg_ack_q |-> reg_rdata_q[flash_protect_pkg::TOP_BYTE_HI:flash_protect_pkg::TOP_BYTE_LO] == 8'h00)
    else $error("Top byte of protection register read nonzero.");

  chk_nibble_fixed: assert property (@(posedge clk) disable iff (!rstn)
    priv_word_write |=> prot_q[flash_protect_pkg::FIXED_NIB_HI:flash_protect_pkg::FIXED_NIB_LO]
      == flash_protect_pkg::FIXED_NIB_VALUE)
    else $error("Reserved upper nibble changed after a write.");

  chk_mid_byte_zero: assert property (@(posedge clk) disable iff (!rstn)
    ##1 prot_q[flash_protect_pkg::MID_BYTE_HI:flash_protect_pkg::MID_BYTE_LO] == 8'h00)
    else $error("Reserved middle byte not zero.");

  chk_prefetch_write: assert property (@(posedge clk) disable iff (!rstn)
    priv_word_write |=> prot_q[flash_protect_pkg::PF_OFF_LO +: flash_protect_pkg::MASTERS]
      == $past(reg_wdata[flash_protect_pkg::PF_OFF_LO +: flash_protect_pkg::MASTERS]))
    else $error("Prefetch-off bits did not take written value.");

  chk_prefetch_gate: assert property (@(posedge clk) disable iff (!rstn)
    flash_prefetch_q |-> $past(!prot_q[flash_protect_pkg::PF_OFF_LO + 32'(acc_master)]
      && (acc_instr ? instruction_prefetch_enable : data_prefetch_enable)))
    else $error("Prefetch issued for disabled master or path.");

  chk_grant_write: assert property (@(posedge clk) disable iff (!rstn)
    priv_word_write |=> prot_q[flash_protect_pkg::MID_BYTE_LO - 1:flash_protect_pkg::GRANT_LO]
      == $past(reg_wdata[flash_protect_pkg::MID_BYTE_LO - 1:flash_protect_pkg::GRANT_LO]))
    else $error("Grant fields did not take written value.");

  chk_none_blocks: assert property (@(posedge clk) disable iff (!rstn)
    acc_valid && req_field == flash_protect_pkg::GRANT_NONE
      |=> acc_error_q && !flash_req_q)
    else $error("Access passed through a no-access field.");

  chk_read_only: assert property (@(posedge clk) disable iff (!rstn)
    acc_valid && acc_write && req_field == flash_protect_pkg::GRANT_READ
      |=> acc_error_q && !flash_write_q)
    else $error("Write passed through a read-only field.");

  chk_reset_value: assert property (@(posedge clk)
    !rstn |=> prot_q == flash_protect_pkg::PROT_RESET)
    else $error("Protection register reset value wrong.");

  chk_refused_write: assert property (@(posedge clk) disable iff (!rstn)
    refused_write |=> reg_err_q && $stable(prot_q))
    else $error("Unprivileged or narrow write was not refused.");

  chk_error_exclusive: assert property (@(posedge clk) disable iff (!rstn)
    acc_error_q |-> !flash_req_q && !flash_prefetch_q)
    else $error("Refused access reached the flash array.");

  chk_answer_once: assert property (@(posedge clk) disable iff (!rstn)
    reg_valid |=> reg_ack_q != reg_err_q)
    else $error("Register access did not get exactly one answer.");

  chk_bus_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !reg_valid |=> !reg_ack_q && !reg_err_q)
    else $error("Register answer without a request.");

  chk_read_data: assert property (@(posedge clk) disable iff (!rstn)
    read_request |=> reg_ack_q && reg_rdata_q == $past(prot_q))
    else $error("Register read returned wrong data.");

  chk_rdata_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !(reg_valid && hit && !reg_write) |=> reg_rdata_q == flash_protect_pkg::ZERO_WORD)
    else $error("Read data bus not zero outside a read.");

  chk_read_passes: assert property (@(posedge clk) disable iff (!rstn)
    granted_read |=> flash_req_q && !acc_error_q && !flash_write_q)
    else $error("Read through a read-enabled field was refused.");

  chk_pf_off_blocks: assert property (@(posedge clk) disable iff (!rstn)
    acc_valid && req_pf_off |=> !flash_prefetch_q)
    else $error("Prefetch issued for a master with prefetch off.");

  chk_pf_allowed: assert property (@(posedge clk) disable iff (!rstn)
    acc_valid && !acc_write && req_field[flash_protect_pkg::GRANT_READ_BIT]
      && !req_pf_off && req_pf_en |=> flash_prefetch_q)
    else $error("Prefetch withheld from an enabled master.");

  chk_pass_through: assert property (@(posedge clk) disable iff (!rstn)
    acc_valid |=> flash_addr_q == $past(acc_addr) && flash_wdata_q == $past(acc_wdata))
    else $error("Forwarded address or data differs from the request.");
endmodule
`default_nettype wire

// File: hw/master_access_check.sv
// Combinational check of one flash request against the protection register.
`timescale 1ns/1ps
`default_nettype none
module master_access_check (
  input wire logic [31:0] prot,
  input wire logic [1:0] master,
  input wire logic is_write,
  input wire logic is_instr,
  input wire logic instruction_prefetch_enable,
  input wire logic data_prefetch_enable,
  output logic allowed,
  output logic prefetch_ok
);
  function automatic logic [1:0] grant_of(input logic [31:0] r, input logic [1:0] m);
    grant_of = r[flash_protect_pkg::GRANT_LO + 2 * m +: flash_protect_pkg::GRANT_W];
  endfunction

  wire logic [1:0] grant;
  wire logic pf_off;
  wire logic pf_enable;

  assign grant = grant_of(prot, master);
  // Bit 0 of a field opens reads and bit 1 opens writes, so 00 blocks all.
  assign allowed = is_write ? grant[flash_protect_pkg::GRANT_WRITE_BIT]
                            : grant[flash_protect_pkg::GRANT_READ_BIT];
  assign pf_off = prot[flash_protect_pkg::PF_OFF_LO + 32'(master)];
  assign pf_enable = is_instr ? instruction_prefetch_enable : data_prefetch_enable;
  assign prefetch_ok = !pf_off && pf_enable;
endmodule
`default_nettype wire

// File: pkg/flash_protect_pkg.sv
// Register map, field layout and reset values of the flash master protection block.
`default_nettype none
package flash_protect_pkg;
  localparam int MASTERS = 4;
  localparam logic [7:0] PROT_OFFSET = 8'h00;
  localparam logic [31:0] PROT_RESET = 32'h00F8_003F;
  localparam logic [31:0] PROT_WRITE_MASK = 32'h000F_00FF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int TOP_BYTE_HI = 31;
  localparam int TOP_BYTE_LO = 24;
  localparam int FIXED_NIB_HI = 23;
  localparam int FIXED_NIB_LO = 20;
  localparam logic [3:0] FIXED_NIB_VALUE = 4'hF;
  localparam int PF_OFF_LO = 16;
  localparam int MID_BYTE_HI = 15;
  localparam int MID_BYTE_LO = 8;
  localparam int GRANT_W = 2;
  localparam int GRANT_LO = 0;
  localparam int GRANT_READ_BIT = 0;
  localparam int GRANT_WRITE_BIT = 1;
  localparam logic [1:0] GRANT_NONE = 2'h0;
  localparam logic [1:0] GRANT_READ = 2'h1;
endpackage
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the flash master protection block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rstn = 1'b0, run = 1'b0, reg_valid = 1'b0, reg_write = 1'b0;
  logic reg_priv = 1'b0, reg_len32 = 1'b0;
  logic instruction_prefetch_enable = 1'b0, data_prefetch_enable = 1'b0;
  logic [7:0] reg_offset = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, w, mreg = 32'h00F8_003F;
  logic reg_ack_q, reg_err_q, flash_req_q, flash_write_q, flash_prefetch_q, acc_error_q;
  logic [31:0] reg_rdata_q, flash_addr_q, flash_wdata_q, acc_addr, acc_wdata;
  logic acc_valid, acc_write, acc_instr;
  logic [1:0] acc_master;
  logic e_req = 1'b0, e_wr = 1'b0, e_pf = 1'b0, e_err = 1'b0;
  logic [31:0] e_addr = 32'h0000_0000, e_wdata = 32'h0000_0000;
  int err_count = 0, num_checks = 0, cycles = 0;
  flash_master_access_protect i_flash_master_access_protect (.clk, .rstn, .reg_valid,
    .reg_offset, .reg_write, .reg_priv, .reg_len32, .reg_wdata, .reg_ack_q, .reg_err_q,
    .reg_rdata_q, .acc_valid, .acc_master, .acc_write, .acc_instr, .acc_addr, .acc_wdata,
    .instruction_prefetch_enable, .data_prefetch_enable, .flash_req_q, .flash_write_q,
    .flash_addr_q, .flash_wdata_q, .flash_prefetch_q, .acc_error_q);
  xbar_master_model i_xbar_master_model (.clk, .run, .acc_valid, .acc_master, .acc_write,
    .acc_instr, .acc_addr, .acc_wdata);
  // Model of the gate: field selected by master, bit0 reads, bit1 writes.
  wire [1:0] fld = mreg[2 * acc_master +: 2];
  wire ok = acc_write ? fld[1] : fld[0];
  wire pf_en = acc_instr ? instruction_prefetch_enable : data_prefetch_enable;
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    {instruction_prefetch_enable, data_prefetch_enable} <= 2'($urandom);
    e_req <= rstn & acc_valid & ok;
    e_wr <= rstn & acc_valid & ok & acc_write;
    e_err <= rstn & acc_valid & ~ok;
    e_pf <= rstn & acc_valid & ok & ~mreg[16 + acc_master] & pf_en;
    e_addr <= rstn ? acc_addr : 32'h0000_0000;
    e_wdata <= rstn ? acc_wdata : 32'h0000_0000;
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      wrap_up;
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  always @(negedge clk) begin
    check("flash_req", 32'(flash_req_q), 32'(e_req));
    check("acc_error", 32'(acc_error_q), 32'(e_err));
    check("flash_prefetch", 32'(flash_prefetch_q), 32'(e_pf));
    check("flash_write", 32'(flash_write_q), 32'(e_wr));
    check("flash_addr", flash_addr_q, e_addr);
    check("flash_wdata", flash_wdata_q, e_wdata);
  end
  // The access bits are write, privileged, full width.
  task automatic reg_acc(input logic [7:0] off, input logic [2:0] wpl, input logic [31:0] wd,
      input logic err, input logic [31:0] rd);
    @(posedge clk);
    reg_valid <= 1'b1;
    reg_offset <= off;
    {reg_write, reg_priv, reg_len32} <= wpl;
    reg_wdata <= wd;
    @(posedge clk);
    reg_valid <= 1'b0;
    #1;
    check("reg_ack", 32'(reg_ack_q), 32'(!err));
    check("reg_err", 32'(reg_err_q), 32'(err));
    check("reg_rdata", reg_rdata_q, rd);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h1a68332e));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    reg_acc(8'h00, 3'b000, 32'h0, 1'b0, 32'h00F8_003F);
    reg_acc(8'h04, 3'b000, 32'h0, 1'b1, 32'h0);
    for (int i = 0; i < 12; i++) begin
      // Reserved fields are written as zero only.
      w = $urandom & 32'h000F_00FF;
      reg_acc(8'h00, 3'b101, w, 1'b1, 32'h0);
      reg_acc(8'h00, 3'b110, w, 1'b1, 32'h0);
      reg_acc(8'h00, 3'b111, w, 1'b0, 32'h0);
      mreg = 32'h00F0_0000 | w;
      reg_acc(8'h00, 3'b000, 32'h0, 1'b0, mreg);
      run <= 1'b1;
      repeat (24) @(posedge clk);
      run <= 1'b0;
      repeat (2) @(posedge clk);
    end
    // A reset between runs must bring back the fixed value over the programmed one.
    rstn <= 1'b0;
    mreg = 32'h00F8_003F;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    reg_acc(8'h00, 3'b000, 32'h0, 1'b0, mreg);
    run <= 1'b1;
    repeat (24) @(posedge clk);
    run <= 1'b0;
    repeat (2) @(posedge clk);
    wrap_up;
  end
endmodule
`default_nettype wire

// File: tb/xbar_master_model.sv
// Behavioural crossbar masters issuing random flash requests.
`timescale 1ns/1ps
`default_nettype none
module xbar_master_model (
  input wire logic clk,
  input wire logic run,
  output logic acc_valid,
  output logic [1:0] acc_master,
  output logic acc_write,
  output logic acc_instr,
  output logic [31:0] acc_addr,
  output logic [31:0] acc_wdata
);
  initial begin
    {acc_valid, acc_master, acc_write, acc_instr, acc_addr, acc_wdata} = '0;
  end
  // Requests pause while run is low, so the register changes only with flash idle.
  always @(posedge clk) begin
    acc_valid <= run & ($urandom_range(0, 3) != 0);
    acc_master <= 2'($urandom);
    acc_write <= 1'($urandom);
    acc_instr <= 1'($urandom);
    acc_addr <= $urandom;
    acc_wdata <= $urandom;
  end
endmodule
`default_nettype wire
